// ---- wdg_timer.sv ----
// watchdog timer with restart sources, forced timeout, led blink and irq routing
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module wdg_timer #(
    parameter int HALF_SEC_CYCLES = wdg_pkg::HALF_SEC_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    // restart and force sources
    input  wire logic        dev_active,
    input  wire logic        game_port_access,
    input  wire logic        kbd_irq,
    input  wire logic        mouse_irq,
    input  wire logic        kbc_force_line,
    // outputs
    output logic             power_indicator_led,
    output logic      [15:0] irq_lines,
    output logic             irq
);

    if (HALF_SEC_CYCLES < 2) begin : g_chk
        $error("HALF_SEC_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic        units_sec;
        logic [7:0]  count_value;
        logic [7:0]  cfg;
        logic        status;
        logic        led_toggle_en;
        logic        kbc_en;
        logic        kbc_prev;
        logic [31:0] prescale;
        logic        half;
        logic [5:0]  sec_cnt;
        logic [7:0]  elapsed;
        logic        led;
        logic [1:0]  irq_sts;
        logic [1:0]  irq_mask;
        logic        irq;
        logic [15:0] irq_lines;
        logic [7:0]  rdata;
    } wdg_state_t;

    wdg_state_t st_reg;
    wdg_state_t st_next;

    localparam logic [31:0] HALF_LAST = 32'(HALF_SEC_CYCLES - 1);

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        addr_hit = (a == target);
    endfunction

    logic       wr_units;
    logic       wr_value;
    logic       wr_cfg;
    logic       wr_ctrl;
    logic       half_tick;
    logic       sec_tick;
    logic       min_tick;
    logic       unit_tick;
    logic       restart;
    logic       force_evt;
    logic       count_evt;
    logic       timeout;
    logic       blink;
    logic [3:0] map;

    always_comb begin
        st_next   = st_reg;
        wr_units  = reg_write && addr_hit(reg_addr, wdg_pkg::ADDR_UNITS);
        wr_value  = reg_write && addr_hit(reg_addr, wdg_pkg::ADDR_VALUE);
        wr_cfg    = reg_write && addr_hit(reg_addr, wdg_pkg::ADDR_CFG);
        wr_ctrl   = reg_write && addr_hit(reg_addr, wdg_pkg::ADDR_CTRL);

        // time base: half-second prescaler, then seconds and minutes
        half_tick = (st_reg.prescale == HALF_LAST);
        sec_tick  = half_tick && st_reg.half;
        min_tick  = sec_tick && (st_reg.sec_cnt == wdg_pkg::SEC_PER_MIN - 6'h01);
        unit_tick = st_reg.units_sec ? sec_tick : min_tick;

        restart = wr_value
            || (dev_active && st_reg.cfg[wdg_pkg::CFG_GAME_BIT] && game_port_access)
            || (dev_active && st_reg.cfg[wdg_pkg::CFG_KBD_BIT] && kbd_irq)
            || (st_reg.cfg[wdg_pkg::CFG_MOUSE_BIT] && mouse_irq);

        force_evt = (wr_ctrl && reg_wdata[wdg_pkg::CTRL_FORCE_BIT])
            || (st_reg.kbc_en && kbc_force_line && !st_reg.kbc_prev);
        count_evt = (st_reg.count_value != 8'h00) && !st_reg.status && !restart
            && unit_tick && (st_reg.elapsed + 8'h01 == st_reg.count_value);
        timeout   = force_evt || count_evt;

        st_next.kbc_prev = kbc_force_line;

        // registers written by software
        if (wr_units) begin
            st_next.units_sec = reg_wdata[wdg_pkg::UNITS_SEC_BIT];
        end
        if (wr_value) begin
            st_next.count_value = reg_wdata;
        end
        if (wr_cfg) begin
            st_next.cfg = reg_wdata;
        end
        if (wr_ctrl) begin
            st_next.status        = reg_wdata[wdg_pkg::CTRL_STATUS_BIT];
            st_next.led_toggle_en = reg_wdata[wdg_pkg::CTRL_LED_BIT];
            st_next.kbc_en        = reg_wdata[wdg_pkg::CTRL_KBC_BIT];
        end
        if (timeout) begin
            st_next.status = 1'b1;
        end

        // counting; restart or clearing status reloads from zero elapsed units
        if (restart || (wr_ctrl && !reg_wdata[wdg_pkg::CTRL_STATUS_BIT] && !timeout)) begin
            st_next.prescale = 32'h0000_0000;
            st_next.half     = 1'b0;
            st_next.sec_cnt  = 6'h00;
            st_next.elapsed  = 8'h00;
        end else begin
            st_next.prescale = half_tick ? 32'h0000_0000 : st_reg.prescale + 32'h0000_0001;
            if (half_tick) begin
                st_next.half = !st_reg.half;
            end
            if (sec_tick) begin
                st_next.sec_cnt = min_tick ? 6'h00 : st_reg.sec_cnt + 6'h01;
            end
            if (unit_tick && !st_reg.status) begin
                st_next.elapsed = st_reg.elapsed + 8'h01;
            end
        end

        // led: a restart also realigns the blink phase, traded for one shared prescaler
        blink = st_reg.led_toggle_en || (st_reg.cfg[wdg_pkg::CFG_LED_BIT] && st_reg.status);
        if (!blink) begin
            st_next.led = 1'b0;
        end else if (half_tick) begin
            st_next.led = !st_reg.led;
        end

        // mapped interrupt follows status while a valid line is selected
        map = st_reg.cfg[wdg_pkg::CFG_MAP_LSB +: 4];
        st_next.irq_lines = 16'h0000;
        if (st_reg.status && map != wdg_pkg::MAP_OFF && map != wdg_pkg::MAP_INVALID) begin
            st_next.irq_lines[map] = 1'b1;
        end

        // sticky event bits, write one to clear, set wins
        if (reg_write && addr_hit(reg_addr, wdg_pkg::ADDR_IRQ_STS)) begin
            st_next.irq_sts = st_reg.irq_sts & ~reg_wdata[1:0];
        end
        if (reg_write && addr_hit(reg_addr, wdg_pkg::ADDR_IRQ_MASK)) begin
            st_next.irq_mask = reg_wdata[1:0];
        end
        if (timeout) begin
            st_next.irq_sts[wdg_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
        end
        if (restart) begin
            st_next.irq_sts[wdg_pkg::IRQ_RESTART_BIT] = 1'b1;
        end
        st_next.irq = |(st_next.irq_sts & st_next.irq_mask);

        // read data valid only in the cycle after the strobe
        st_next.rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                wdg_pkg::ADDR_UNITS:    st_next.rdata = {st_reg.units_sec, 7'h00};
                wdg_pkg::ADDR_VALUE:    st_next.rdata = st_reg.count_value;
                wdg_pkg::ADDR_CFG:      st_next.rdata = st_reg.cfg;
                wdg_pkg::ADDR_CTRL:     st_next.rdata = {4'h0, st_reg.kbc_en, 1'b0,
                                                         st_reg.led_toggle_en, st_reg.status};
                wdg_pkg::ADDR_IRQ_STS:  st_next.rdata = {6'h00, st_reg.irq_sts};
                wdg_pkg::ADDR_IRQ_MASK: st_next.rdata = {6'h00, st_reg.irq_mask};
                default:                st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg             <= '0;
            st_reg.units_sec   <= wdg_pkg::RST_UNITS[wdg_pkg::UNITS_SEC_BIT];
            st_reg.count_value <= wdg_pkg::RST_VALUE;
            st_reg.cfg         <= wdg_pkg::RST_CFG;
            st_reg.irq_sts     <= wdg_pkg::RST_IRQ;
            st_reg.irq_mask    <= wdg_pkg::RST_IRQ;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata           = st_reg.rdata;
    assign power_indicator_led = st_reg.led;
    assign irq_lines           = st_reg.irq_lines;
    assign irq                 = st_reg.irq;

endmodule

`default_nettype wire

// ---- wdg_pkg.sv ----
// constants of the watchdog timer block
package wdg_pkg;
    // register addresses
    localparam logic [7:0] ADDR_UNITS    = 8'hF1;
    localparam logic [7:0] ADDR_VALUE    = 8'hF2;
    localparam logic [7:0] ADDR_CFG      = 8'hF3;
    localparam logic [7:0] ADDR_CTRL     = 8'hF4;
    localparam logic [7:0] ADDR_IRQ_STS  = 8'hF5;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hF6;
    // reset values
    localparam logic [7:0] RST_UNITS = 8'h00;
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [7:0] RST_CFG   = 8'h00;
    localparam logic [1:0] RST_IRQ   = 2'h0;
    // field positions
    localparam int UNITS_SEC_BIT   = 7;
    localparam int CFG_GAME_BIT    = 0;
    localparam int CFG_KBD_BIT     = 1;
    localparam int CFG_MOUSE_BIT   = 2;
    localparam int CFG_LED_BIT     = 3;
    localparam int CFG_MAP_LSB     = 4;
    localparam int CTRL_STATUS_BIT = 0;
    localparam int CTRL_LED_BIT    = 1;
    localparam int CTRL_FORCE_BIT  = 2;
    localparam int CTRL_KBC_BIT    = 3;
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_RESTART_BIT = 1;
    // interrupt mapping codes
    localparam logic [3:0] MAP_OFF     = 4'h0;
    localparam logic [3:0] MAP_INVALID = 4'h2;
    // timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int HALF_SEC_NS     = 500_000_000;
    localparam int HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;
endpackage

// ---- wdg_timer_properties.sv ----
// port-level checks of the watchdog timer
`timescale 1ns/1ns
`default_nettype none
module wdg_timer_properties (
    // clock, reset and register port
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    // force line and interrupts
    input wire logic        kbc_force_line,
    input wire logic [15:0] irq_lines,
    input wire logic        irq
);
    logic [3:0] map_reg;
    logic       kbc_en_reg;
    logic       wr_cfg, wr_ctrl, clr_irq, map_ok;
    assign wr_cfg  = reg_write && reg_addr == wdg_pkg::ADDR_CFG;
    assign wr_ctrl = reg_write && reg_addr == wdg_pkg::ADDR_CTRL;
    assign clr_irq = reg_write && reg_addr >= wdg_pkg::ADDR_IRQ_STS;
    assign map_ok  = map_reg != wdg_pkg::MAP_OFF && map_reg != wdg_pkg::MAP_INVALID;
    // shadows of the routing code and line-force enable, kept from bus writes alone
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            map_reg    <= 4'h0;
            kbc_en_reg <= 1'b0;
        end else begin
            map_reg    <= wr_cfg ? reg_wdata[7:4] : map_reg;
            kbc_en_reg <= wr_ctrl ? reg_wdata[3] : kbc_en_reg;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    AST_RDATA_IDLE: assert property (!$past(reg_read) || $past(reg_addr) < wdg_pkg::ADDR_UNITS
        || $past(reg_addr) > wdg_pkg::ADDR_IRQ_MASK |-> reg_rdata == 8'h00) else $error("read data not idle");
    AST_CTRL_READ: assert property ($past(reg_read && reg_addr == wdg_pkg::ADDR_CTRL)
        |-> !reg_rdata[2] && reg_rdata[7:4] == 4'h0) else $error("write-only control bits read back");
    AST_NO_LINE_0_2: assert property (!irq_lines[0] && !irq_lines[2]) else $error("reserved irq line");
    AST_ONE_LINE: assert property ($onehot0(irq_lines)) else $error("several irq lines high");
    AST_MAP_OFF: assert property (map_reg == 4'h0 && $past(map_reg) == 4'h0 |-> irq_lines == 16'h0000)
        else $error("irq line high while routing off");
    AST_FORCE: assert property (wr_ctrl && reg_wdata[2] && map_ok
        |-> ##2 irq_lines == 16'h0001 << $past(map_reg, 2)) else $error("forced timeout not routed");
    AST_KBC_EDGE: assert property ($rose(kbc_force_line) && kbc_en_reg && map_ok && !wr_ctrl
        |-> ##2 irq_lines == 16'h0001 << $past(map_reg, 2)) else $error("line edge did not force timeout");
    AST_IRQ_HOLD: assert property (irq && !clr_irq && !$past(clr_irq) |=> irq)
        else $error("irq dropped without clear");
    AST_LINES_HOLD: assert property (irq_lines != 16'h0000 && !wr_cfg && !wr_ctrl && !$past(wr_cfg)
        && !$past(wr_ctrl) |=> $stable(irq_lines)) else $error("routed irq changed on its own");
endmodule
bind wdg_timer wdg_timer_properties u_props (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .kbc_force_line, .irq_lines, .irq);
`default_nettype wire

// ---- tb_wdg_timer.sv ----
// self-checking testbench of the watchdog timer
`timescale 1ns/1ns
`default_nettype none
module tb_wdg_timer;
    logic        mclk, nrst, reg_write, reg_read, dev_active, kbc_force_line, power_indicator_led, irq;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [15:0] irq_lines, lf;
    logic [2:0]  src;
    logic [7:0]  exp_q[$];
    logic        rd_d = 1'b0;
    int          bad_count, samples_checked, n, cyc = 0;
    // short half-second so a minute is 480 cycles
    wdg_timer #(.HALF_SEC_CYCLES(4)) dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .dev_active(dev_active),
        .game_port_access(src[0]), .kbd_irq(src[1]), .mouse_irq(src[2]), .kbc_force_line(kbc_force_line),
        .power_indicator_led(power_indicator_led), .irq_lines(irq_lines), .irq(irq));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // read data stands one cycle only, so the oldest note is taken exactly then
    always @(posedge mclk) begin
        if (rd_d)
            chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
        rd_d <= reg_read;
        cyc  <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk);
        reg_read <= 1'b0;
    endtask
    task automatic wait_chk(input int c, input logic [15:0] e, input logic ei);
        repeat (c) @(posedge mclk);
        chk("irq_lines", e, irq_lines);
        chk("irq", {15'h0000, ei}, {15'h0000, irq});
    endtask
    task automatic clr();
        wr(wdg_pkg::ADDR_CTRL, 8'h00);
        wr(wdg_pkg::ADDR_IRQ_STS, 8'h03);
    endtask
    task automatic pulse(input int s);
        repeat (10) @(posedge mclk);
        src <= 3'(1 << s);
        @(posedge mclk);
        src <= 3'h0;
    endtask
    task automatic blink(input int e);
        logic p;
        n = 0;
        repeat (4) @(posedge mclk);
        p = power_indicator_led;
        repeat (16) begin
            @(posedge mclk);
            n += (e == 0) ? int'(power_indicator_led !== 1'b0) : int'(power_indicator_led !== p);
            p = power_indicator_led;
        end
        chk("led", 16'(e), 16'(n));
    endtask
    initial begin
        {nrst, reg_write, reg_read, kbc_force_line, src, reg_addr, reg_wdata} = '0;
        dev_active = 1'b1;
        lf = 16'hA5AD;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        for (logic [7:0] a = 8'hF1; a <= 8'hF4; a++)
            rd(a, 8'h00);
        rd(8'hF7, 8'h00);
        repeat (4) begin
            lf = lfsr(lf);
            wr(wdg_pkg::ADDR_VALUE, lf[7:0]);
            rd(wdg_pkg::ADDR_VALUE, lf[7:0]);
        end
        wr(wdg_pkg::ADDR_IRQ_MASK, 8'h01);
        wr(wdg_pkg::ADDR_CFG, 8'h50);
        wr(wdg_pkg::ADDR_VALUE, 8'h01);
        wait_chk(460, 16'h0000, 1'b0);
        wait_chk(40, 16'h0020, 1'b1);
        rd(wdg_pkg::ADDR_CTRL, 8'h01);
        clr();
        wr(wdg_pkg::ADDR_UNITS, 8'h80);
        wr(wdg_pkg::ADDR_VALUE, 8'h03);
        wait_chk(20, 16'h0000, 1'b0);
        wait_chk(10, 16'h0020, 1'b1);
        clr();
        for (int i = 0; i < 4; i++) begin
            dev_active <= (i != 3);
            wr(wdg_pkg::ADDR_CFG, 8'h50 | 8'(1 << (i % 3)));
            wr(wdg_pkg::ADDR_VALUE, 8'h02);
            repeat (4) pulse(i % 3);
            wait_chk(1, (i == 3) ? 16'h0020 : 16'h0000, i == 3);
            wr(wdg_pkg::ADDR_CFG, 8'h50);
            repeat (2) pulse(i % 3);
            wait_chk(1, 16'h0020, 1'b1);
            clr();
        end
        wr(wdg_pkg::ADDR_VALUE, 8'h00);
        wait_chk(60, 16'h0000, 1'b0);
        for (int m = 0; m < 16; m++) begin
            wr(wdg_pkg::ADDR_CFG, 8'(m << 4));
            wr(wdg_pkg::ADDR_CTRL, 8'h04);
            wait_chk(2, (m == 0 || m == 2) ? 16'h0000 : 16'(1 << m), 1'b1);
            wr(wdg_pkg::ADDR_IRQ_MASK, 8'h00);
            wait_chk(2, (m == 0 || m == 2) ? 16'h0000 : 16'(1 << m), 1'b0);
            wr(wdg_pkg::ADDR_IRQ_MASK, 8'h01);
            clr();
        end
        wr(wdg_pkg::ADDR_CFG, 8'h50);
        wr(wdg_pkg::ADDR_CTRL, 8'h08);
        kbc_force_line <= 1'b1;
        wait_chk(3, 16'h0020, 1'b1);
        rd(wdg_pkg::ADDR_CTRL, 8'h09);
        wr(wdg_pkg::ADDR_CTRL, 8'h08);
        wait_chk(4, 16'h0000, 1'b1);
        kbc_force_line <= 1'b0;
        clr();
        kbc_force_line <= 1'b1;
        wait_chk(4, 16'h0000, 1'b0);
        wr(wdg_pkg::ADDR_CTRL, 8'h02);
        blink(4);
        wr(wdg_pkg::ADDR_CTRL, 8'h00);
        blink(0);
        wr(wdg_pkg::ADDR_CFG, 8'h58);
        wr(wdg_pkg::ADDR_CTRL, 8'h04);
        blink(4);
        clr();
        blink(0);
        end_of_test();
    end
endmodule
`default_nettype wire
